// ---- ieq_regs.svh ----
`ifndef IEQ_REGS_SVH
`define IEQ_REGS_SVH
// Queue geometry.
`define IEQ_DEPTH 20
// Error codes, signed 16 bit.
`define IEQ_NO_ERROR 16'sd0
`define IEQ_OVERFLOW -16'sd350
`define IEQ_HDR_LONG -16'sd112
`define IEQ_NUM_OVF -16'sd123
`define IEQ_NUM_DIGITS -16'sd124
`define IEQ_BLOCK_BASE -16'sd160
`define IEQ_EXPR_BASE -16'sd170
`define IEQ_TRIG_IGN -16'sd211
`define IEQ_INIT_IGN -16'sd213
`define IEQ_STR_LONG -16'sd223
`define IEQ_QRY_INT -16'sd410
`define IEQ_QRY_UNT -16'sd420
`define IEQ_QRY_DEAD -16'sd430
`define IEQ_QRY_IDN -16'sd440
`define IEQ_RS_FRAME 16'sd511
`define IEQ_RS_OVERRUN 16'sd512
`define IEQ_RS_PARITY 16'sd513
`define IEQ_ONLY_RS 16'sd514
`define IEQ_IN_LOCAL 16'sd550
// Parser limits.
`define IEQ_HDR_MAX 12
`define IEQ_EXP_MAX 32000
`define IEQ_DIGIT_MAX 255
`define IEQ_STR_MAX 40
`define IEQ_MSG_MAX 80
// Menu idle time-out.
`define IEQ_MENU_TIMEOUT_S 30
`define IEQ_CLK_HZ 20000000
`define IEQ_MENU_CYCLES (`IEQ_MENU_TIMEOUT_S * `IEQ_CLK_HZ)
`endif

// ---- ieq_pkg.sv ----
package ieq_pkg;
    // One parsed-event report from the command front end.
    typedef struct packed {
        logic hdr_done;       // A header word has ended.
        logic [7:0] hdr_len;  // Its length in characters.
        logic num_done;       // A numeric parameter has ended.
        logic [15:0] exp_val; // Its exponent magnitude.
        logic exp_neg;        // Exponent sign.
        logic [8:0] digits;   // Mantissa digits after leading zeros.
        logic block_seen;     // Block data was seen.
        logic [3:0] block_sub;// Block error subcode 0..8.
        logic expr_seen;      // An expression was seen.
        logic [3:0] expr_sub; // Expression error subcode 0..8.
        logic str_done;       // A string parameter has ended.
        logic [7:0] str_len;  // Its length in characters.
    } ieq_parse_t;
    // Execution and interface events.
    typedef struct packed {
        logic trig;           // Bus trigger or trigger command.
        logic trig_src_bus;   // Trigger source is bus.
        logic trig_armed;     // Trigger system initiated.
        logic init_cmd;       // Initiate command.
        logic busy;           // Previous operation in progress.
        logic query;          // New response-producing command.
        logic out_pending;    // Output buffer holds unread data.
        logic talk;           // Addressed to talk.
        logic resp_ready;     // A response is available.
        logic out_ovf;        // Response overflows output buffer.
        logic in_full;        // Input buffer full.
        logic idn_not_last;   // Identification query not last.
        logic ser_frame;      // Serial framing error.
        logic ser_overrun;    // Serial overrun.
        logic ser_parity;     // Serial parity error.
        logic ser_only_cmd;   // Local/remote/lockout command.
        logic from_serial;    // Command came over the serial link.
        logic serial_cmd;     // Any command over the serial link.
        logic local_state;    // Device is in local state.
    } ieq_exec_t;
    // Queue states.
    typedef enum logic [2:0] {
        IEQ_EMPTY = 3'b001,
        IEQ_FILL = 3'b010,
        IEQ_LOCKED = 3'b100
    } ieq_state_t;
endpackage : ieq_pkg

// ---- ieq_detect.sv ----
`timescale 1ns/10ps
`include "ieq_regs.svh"
module ieq_detect
    import ieq_pkg::*;
(
    // Event inputs.
    input wire ieq_parse_t parse,
    input wire ieq_exec_t exec,
    // Selected error.
    output logic err_valid,
    output logic signed [15:0] err_code,
    // Refusal strobes.
    output logic refuse,
    output logic discard_resp
);
    // Fixed-priority pick of at most one code per cycle.
    always_comb begin
        err_valid = 1'b1;
        err_code = `IEQ_NO_ERROR;
        refuse = 1'b0;
        discard_resp = 1'b0;
        if (exec.ser_frame) begin
            err_code = `IEQ_RS_FRAME;
        end else if (exec.ser_overrun) begin
            err_code = `IEQ_RS_OVERRUN;
        end else if (exec.ser_parity) begin
            err_code = `IEQ_RS_PARITY;
        end else if (exec.ser_only_cmd && !exec.from_serial) begin
            err_code = `IEQ_ONLY_RS;
            refuse = 1'b1;
        end else if (exec.serial_cmd && exec.local_state) begin
            err_code = `IEQ_IN_LOCAL;
            refuse = 1'b1;
        end else if (parse.hdr_done && parse.hdr_len > 8'(`IEQ_HDR_MAX)) begin
            err_code = `IEQ_HDR_LONG;
        end else if (parse.num_done && !parse.exp_neg &&
                     parse.exp_val > 16'(`IEQ_EXP_MAX)) begin
            err_code = `IEQ_NUM_OVF;
        end else if (parse.num_done && parse.digits > 9'(`IEQ_DIGIT_MAX)) begin
            err_code = `IEQ_NUM_DIGITS;
        end else if (parse.block_seen) begin
            err_code = `IEQ_BLOCK_BASE - 16'(parse.block_sub);
            refuse = 1'b1;
        end else if (parse.expr_seen) begin
            err_code = `IEQ_EXPR_BASE - 16'(parse.expr_sub);
            refuse = 1'b1;
        end else if (parse.str_done && parse.str_len > 8'(`IEQ_STR_MAX)) begin
            err_code = `IEQ_STR_LONG;
            refuse = 1'b1;
        end else if (exec.trig && !(exec.trig_src_bus && exec.trig_armed)) begin
            err_code = `IEQ_TRIG_IGN;
            refuse = 1'b1;
        end else if (exec.init_cmd && exec.busy) begin
            err_code = `IEQ_INIT_IGN;
            refuse = 1'b1;
        end else if (exec.query && exec.out_pending) begin
            err_code = `IEQ_QRY_INT;
            discard_resp = 1'b1;
        end else if (exec.talk && !exec.resp_ready) begin
            err_code = `IEQ_QRY_UNT;
        end else if (exec.out_ovf && exec.in_full) begin
            err_code = `IEQ_QRY_DEAD;
            discard_resp = 1'b1;
        end else if (exec.idn_not_last) begin
            err_code = `IEQ_QRY_IDN;
        end else begin
            err_valid = 1'b0; // No error this cycle.
        end
    end
endmodule : ieq_detect

// ---- ieq_top.sv ----
// Operation
// - Reads return oldest unread entry first.
// - Full queue: newest becomes -350, drop rest.
// - Empty read gives +0; empty queue with menu open shows no-errors flag.
// - Clear-status and power-up empty queue; reads remove.
// - Instrument reset leaves queue untouched.
// - One beeper pulse per generated error.
// - Annunciator lit while queue holds entries.
// - Menu exit or 30 s idle clears all.
// - Report is code plus message characters by index, 80 max.
// - Header over 12 characters logs -112.
// - Exponent over 32000 -123, digits over 255 -124.
// - Block data -160..-168, expressions -170..-178.
// - Unarmed or non-bus trigger ignored, logs -211.
// - Initiate while busy refused, logs -213.
// - String over 40 characters refused, -223.
// - Query over unread output keeps old, -410.
// - Talk without response logs -420.
// - Output overflow with full input logs -430.
// - Serial framing 511, overrun 512, parity 513.
// - Serial-only commands elsewhere refused with 514.
// - Serial commands in local state refused, 550.
// - Device clear flushes buffers, keeps queue.
`timescale 1ns/10ps
`include "ieq_regs.svh"
module ieq_top
    import ieq_pkg::*;
#(
    parameter int DEPTH = `IEQ_DEPTH,
    parameter int MENU_CYCLES = `IEQ_MENU_CYCLES
) (
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RST,
    // Parser and execution events.
    input wire ieq_parse_t PARSE,
    input wire ieq_exec_t EXEC,
    // Common commands and device clear.
    input wire logic CLEAR_STATUS,
    input wire logic INSTR_RESET,
    input wire logic DEVICE_CLEAR,
    // Error read port.
    input wire logic READ_REQ,
    input wire logic [6:0] MSG_IDX,
    output logic READ_VALID,
    output logic signed [15:0] READ_CODE,
    output logic [7:0] MSG_CHAR,
    output logic [6:0] MSG_LEN,
    // Local error-view menu.
    input wire logic MENU_OPEN,
    input wire logic MENU_EXIT,
    input wire logic MENU_ACTIVITY,
    output logic NO_ERRORS_SHOWN,
    // Annunciator, beeper and command refusal.
    output logic ERROR_ANNUNCIATOR,
    output logic BEEP,
    output logic CMD_REFUSED,
    output logic RESP_DISCARD,
    output logic FLUSH_BUFFERS,
    output logic PARSER_READY
);
    // Pointer and idle-timer widths.
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(MENU_CYCLES + 1);

    // Error selection from the event buses.
    logic err_valid;
    logic signed [15:0] err_code;
    logic refuse;
    logic discard_resp;

    ieq_detect u_detect (
        .parse(PARSE),
        .exec(EXEC),
        .err_valid(err_valid),
        .err_code(err_code),
        .refuse(refuse),
        .discard_resp(discard_resp)
    );

    // Queue storage and pointers.
    logic signed [15:0] mem [DEPTH];
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] wr_ptr;
    logic [PW:0] count;
    ieq_state_t state;
    logic [PW-1:0] next_rd_ptr;
    logic [PW-1:0] next_wr_ptr;
    logic [PW:0] next_count;
    ieq_state_t next_state;
    logic wr_en;
    logic [PW-1:0] wr_addr;
    logic signed [15:0] wr_data;

    // Menu idle timer.
    logic [CW-1:0] idle_cnt;
    logic [CW-1:0] next_idle_cnt;
    logic menu_clear;

    // Read answer registers.
    logic signed [15:0] next_read_code;
    logic next_read_valid;
    logic next_beep;
    logic next_refused;
    logic next_discard;
    logic next_flush;

    // Wrap helper for the circular pointers.
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    // Menu exit or idle time-out clears the whole queue.
    always_comb begin
        next_idle_cnt = '0;
        menu_clear = 1'b0;
        if (MENU_OPEN) begin
            if (MENU_EXIT) begin
                menu_clear = 1'b1;
            end else if (MENU_ACTIVITY) begin
                next_idle_cnt = '0;
            end else if (idle_cnt == CW'(MENU_CYCLES - 1)) begin
                menu_clear = 1'b1;
            end else begin
                next_idle_cnt = idle_cnt + 1'b1;
            end
        end
    end

    // Queue next-state: reads pop the oldest, errors push, overflow locks.
    always_comb begin
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        next_count = count;
        next_state = state;
        wr_en = 1'b0;
        wr_addr = wr_ptr;
        wr_data = err_code;
        next_read_valid = 1'b0;
        next_read_code = READ_CODE;
        if (READ_REQ) begin
            next_read_valid = 1'b1;
            if (count == '0) begin
                next_read_code = `IEQ_NO_ERROR;
            end else begin
                next_read_code = mem[rd_ptr];
                next_rd_ptr = bump(rd_ptr);
                next_count = count - 1'b1;
            end
        end
        // Errors push unless the queue is full and no read frees a slot this cycle.
        if (err_valid) begin
            if (count == (PW+1)'(DEPTH) && !(READ_REQ)) begin
                if (state != IEQ_LOCKED) begin
                    wr_en = 1'b1;
                    wr_addr = (wr_ptr == '0) ? PW'(DEPTH - 1) : wr_ptr - 1'b1;
                    wr_data = `IEQ_OVERFLOW;
                end
            end else begin
                wr_en = 1'b1;
                next_wr_ptr = bump(wr_ptr);
                next_count = next_count + 1'b1;
            end
        end
        // Lock follows a full queue until something is read.
        if (next_count == '0) begin
            next_state = IEQ_EMPTY;
        end else if (READ_REQ && count != '0) begin
            next_state = IEQ_FILL;
        end else if (wr_en && wr_data == `IEQ_OVERFLOW && count == (PW+1)'(DEPTH)) begin
            next_state = IEQ_LOCKED;
        end else if (state == IEQ_EMPTY) begin
            next_state = IEQ_FILL;
        end
        // Clear status and the menu empty the queue; instrument reset does not.
        if (CLEAR_STATUS || menu_clear) begin
            next_rd_ptr = '0;
            next_wr_ptr = '0;
            next_count = '0;
            next_state = IEQ_EMPTY;
            wr_en = 1'b0;
        end
        // INSTR_RESET and DEVICE_CLEAR are intentionally not used here.
    end

    // Side strobes for the beeper and the command front end.
    always_comb begin
        next_beep = err_valid;
        next_refused = refuse;
        next_discard = discard_resp;
        next_flush = DEVICE_CLEAR;
    end

    // Register all state but the storage array; power-up empties the queue.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count <= '0;
            state <= IEQ_EMPTY;
            idle_cnt <= '0;
            READ_VALID <= 1'b0;
            READ_CODE <= `IEQ_NO_ERROR;
            BEEP <= 1'b0;
            CMD_REFUSED <= 1'b0;
            RESP_DISCARD <= 1'b0;
            FLUSH_BUFFERS <= 1'b0;
        end else begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count <= next_count;
            state <= next_state;
            idle_cnt <= next_idle_cnt;
            READ_VALID <= next_read_valid;
            READ_CODE <= next_read_code;
            BEEP <= next_beep;
            CMD_REFUSED <= next_refused;
            RESP_DISCARD <= next_discard;
            FLUSH_BUFFERS <= next_flush;
        end
    end

    // Storage array write port; contents need no reset.
    always_ff @(posedge CLK_SYS) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Annunciator and front-panel empty indication.
    assign ERROR_ANNUNCIATOR = (count != '0);
    assign NO_ERRORS_SHOWN = MENU_OPEN && (count == '0);
    assign PARSER_READY = !FLUSH_BUFFERS;

    // Message text lookup for the last code read, at most 80 characters.
    logic [8*24-1:0] msg_text; // Left-padded with zero bytes.
    logic [6:0] msg_len;
    always_comb begin
        msg_text = '0;
        msg_len = 7'h0;
        case (READ_CODE)
            `IEQ_NO_ERROR:
                msg_text = 192'("No error");
            `IEQ_OVERFLOW:
                msg_text = 192'("Queue overflow");
            `IEQ_HDR_LONG:
                msg_text = 192'("Mnemonic too long");
            `IEQ_NUM_OVF:
                msg_text = 192'("Numeric overflow");
            `IEQ_NUM_DIGITS:
                msg_text = 192'("Too many digits");
            `IEQ_TRIG_IGN:
                msg_text = 192'("Trigger ignored");
            `IEQ_INIT_IGN:
                msg_text = 192'("Init ignored");
            `IEQ_STR_LONG:
                msg_text = 192'("Too much data");
            `IEQ_QRY_INT:
                msg_text = 192'("Query INTERRUPTED");
            `IEQ_QRY_UNT:
                msg_text = 192'("Query UNTERMINATED");
            `IEQ_QRY_DEAD:
                msg_text = 192'("Query DEADLOCKED");
            `IEQ_QRY_IDN:
                msg_text = 192'("Query after indefinite");
            `IEQ_RS_FRAME:
                msg_text = 192'("RS-232 framing error");
            `IEQ_RS_OVERRUN:
                msg_text = 192'("RS-232 overrun error");
            `IEQ_RS_PARITY:
                msg_text = 192'("RS-232 parity error");
            `IEQ_ONLY_RS:
                msg_text = 192'("Allowed only RS-232");
            `IEQ_IN_LOCAL:
                msg_text = 192'("Not allowed in local");
            default: begin
                // Block and expression ranges share one text each.
                if (READ_CODE <= `IEQ_BLOCK_BASE && READ_CODE >= `IEQ_BLOCK_BASE - 16'sd8) begin
                    msg_text = 192'("Block data error");
                end else begin
                    msg_text = 192'("Expression error");
                end
            end
        endcase
        // Length is the count of non-zero characters.
        for (int i = 0; i < 24; i++) begin
            if (msg_text[8*i +: 8] != 8'h0) begin
                msg_len = 7'(i + 1);
            end
        end
    end

    // Character pick, first character at index 0; bounded by the 80 limit.
    always_comb begin
        MSG_LEN = msg_len;
        MSG_CHAR = 8'h20;
        if (MSG_IDX < msg_len && MSG_IDX < 7'(`IEQ_MSG_MAX)) begin
            MSG_CHAR = msg_text[8*(7'(msg_len) - 7'h1 - MSG_IDX) +: 8];
        end
    end
endmodule : ieq_top

// ---- ieq_top_properties.sv ----
`timescale 1ns/10ps
module ieq_top_properties
    import ieq_pkg::*;
#(
    parameter int DEPTH = 20,
    parameter int MENU_CYCLES = 50
) (
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RST,
    // Event and command inputs.
    input wire ieq_parse_t PARSE,
    input wire ieq_exec_t EXEC,
    input wire logic CLEAR_STATUS,
    input wire logic INSTR_RESET,
    input wire logic DEVICE_CLEAR,
    input wire logic READ_REQ,
    input wire logic MENU_OPEN,
    input wire logic MENU_EXIT,
    input wire logic MENU_ACTIVITY,
    // Observed outputs.
    input wire logic READ_VALID,
    input wire logic signed [15:0] READ_CODE,
    input wire logic [6:0] MSG_LEN,
    input wire logic ERROR_ANNUNCIATOR,
    input wire logic BEEP,
    input wire logic FLUSH_BUFFERS,
    input wire logic PARSER_READY
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // High when no error source pulses in this cycle.
    logic quiet;
    // Cycles the menu has been open with nothing happening.
    logic [31:0] idle;
    logic [31:0] next_idle;
    // Quiet cycles are those that cannot push an entry.
    always_comb begin
        quiet = (PARSE == '0) && !(EXEC.trig || EXEC.init_cmd || EXEC.query || EXEC.talk
            || EXEC.out_ovf || EXEC.idn_not_last || EXEC.ser_frame || EXEC.ser_overrun
            || EXEC.ser_parity || EXEC.ser_only_cmd || EXEC.serial_cmd);
    end
    // Idle counter restarts on any activity, push or menu close.
    always_comb begin
        next_idle = idle + 32'h1;
        if (!MENU_OPEN || MENU_ACTIVITY || !quiet) begin
            next_idle = 32'h0;
        end
    end
    // The counter registers its next value, or zero during reset.
    always_ff @(posedge CLK_SYS) begin
        idle <= RST ? 32'h0 : next_idle;
    end
    // A cycle with entries held and no read, clear status or open menu.
    sequence keep_s;
        ERROR_ANNUNCIATOR && !READ_REQ && !CLEAR_STATUS && !MENU_OPEN;
    endsequence
    a_frame_beeps: assert property (EXEC.ser_frame && !CLEAR_STATUS |=> BEEP)
        else $error("no beep after a framing error");
    a_read_answers: assert property (READ_REQ |=> READ_VALID)
        else $error("read not answered in one cycle");
    a_empty_zero: assert property (!ERROR_ANNUNCIATOR && READ_REQ && quiet
        |=> READ_CODE == 16'sh0)
        else $error("empty read did not give zero");
    a_clear_empties: assert property (CLEAR_STATUS |=> !ERROR_ANNUNCIATOR)
        else $error("clear status left entries");
    a_reset_keeps: assert property (keep_s ##0 INSTR_RESET |=> ERROR_ANNUNCIATOR)
        else $error("instrument reset touched queue");
    a_annunc_holds: assert property (keep_s |=> ERROR_ANNUNCIATOR [*1])
        else $error("annunciator dropped with entries held");
    a_exit_clears: assert property (MENU_OPEN && MENU_EXIT |=> !ERROR_ANNUNCIATOR)
        else $error("menu exit left entries");
    a_idle_clears: assert property (idle > MENU_CYCLES + 1 |-> !ERROR_ANNUNCIATOR)
        else $error("menu idle time-out left entries");
    a_msg_bound: assert property (READ_VALID |-> MSG_LEN <= 7'd80)
        else $error("message longer than limit");
    a_flush_next: assert property (DEVICE_CLEAR |=> FLUSH_BUFFERS && !PARSER_READY)
        else $error("device clear did not flush");
endmodule : ieq_top_properties

bind ieq_top ieq_top_properties #(.DEPTH(DEPTH), .MENU_CYCLES(MENU_CYCLES)) u_props (
    .CLK_SYS(CLK_SYS), .RST(RST), .PARSE(PARSE), .EXEC(EXEC),
    .CLEAR_STATUS(CLEAR_STATUS), .INSTR_RESET(INSTR_RESET), .DEVICE_CLEAR(DEVICE_CLEAR),
    .READ_REQ(READ_REQ), .MENU_OPEN(MENU_OPEN), .MENU_EXIT(MENU_EXIT),
    .MENU_ACTIVITY(MENU_ACTIVITY), .READ_VALID(READ_VALID), .READ_CODE(READ_CODE),
    .MSG_LEN(MSG_LEN), .ERROR_ANNUNCIATOR(ERROR_ANNUNCIATOR), .BEEP(BEEP),
    .FLUSH_BUFFERS(FLUSH_BUFFERS), .PARSER_READY(PARSER_READY)
);

// ---- ieq_host_model.sv ----
`timescale 1ns/10ps
module ieq_host_model
    import ieq_pkg::*;
(
    // Request from the bench, changed at the falling edge.
    input wire logic go,
    input wire logic [4:0] sel,
    // Events the host's traffic raises at the block.
    output ieq_parse_t parse,
    output ieq_exec_t exec
);
    // Each selection is one host action; local state stays off since
    // the host enters remote first, except in case 18.
    always_comb begin
        parse = '0;
        exec = '0;
        if (go) begin
            case (sel)
            5'd0: parse = '{hdr_done: 1'b1, hdr_len: 8'h0d, default: '0};
            5'd1: parse = '{hdr_done: 1'b1, hdr_len: 8'h0c, default: '0};
            5'd2: parse = '{num_done: 1'b1, exp_val: 16'h7d01, default: '0};
            5'd3: parse = '{num_done: 1'b1, digits: 9'h100, default: '0};
            5'd4: parse = '{block_seen: 1'b1, block_sub: 4'h8, default: '0};
            5'd5: parse = '{expr_seen: 1'b1, default: '0};
            5'd6: parse = '{str_done: 1'b1, str_len: 8'h29, default: '0};
            5'd7: parse = '{str_done: 1'b1, str_len: 8'h28, default: '0};
            5'd8: exec = '{trig: 1'b1, default: '0};
            5'd9: exec = '{init_cmd: 1'b1, busy: 1'b1, default: '0};
            5'd10: exec = '{query: 1'b1, out_pending: 1'b1, default: '0};
            5'd11: exec = '{talk: 1'b1, default: '0};
            5'd12: exec = '{out_ovf: 1'b1, in_full: 1'b1, default: '0};
            5'd13: exec = '{idn_not_last: 1'b1, default: '0};
            5'd14: exec = '{ser_frame: 1'b1, default: '0};
            5'd15: exec = '{ser_overrun: 1'b1, default: '0};
            5'd16: exec = '{ser_parity: 1'b1, default: '0};
            5'd17: exec = '{ser_only_cmd: 1'b1, default: '0};
            5'd18: exec = '{serial_cmd: 1'b1, local_state: 1'b1, default: '0};
            default: exec = '{trig: 1'b1, trig_src_bus: 1'b1, trig_armed: 1'b1, default: '0};
            endcase
        end
    end
endmodule : ieq_host_model

// ---- instrument_error_queue_tb_top.sv ----
`timescale 1ns/10ps
module instrument_error_queue_tb_top
    import ieq_pkg::*;
;
    // Expected code for each host action; zero means nothing is queued.
    localparam int EXP [20] = '{-112, 0, -123, -124, -168, -170, -223, 0, -211, -213,
        -410, -420, -430, -440, 511, 512, 513, 514, 550, 0};
    // Clock, reset and stimulus.
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic [4:0] sel = 5'h0;
    logic clear_status = 1'b0;
    logic instr_reset = 1'b0;
    logic device_clear = 1'b0;
    logic read_req = 1'b0;
    logic [6:0] msg_idx = 7'h0;
    logic menu_open = 1'b0;
    logic menu_exit = 1'b0;
    logic menu_activity = 1'b0;
    // Block outputs.
    ieq_parse_t parse;
    ieq_exec_t exec;
    logic read_valid, error_annunciator, beep, no_errors_shown;
    logic cmd_refused, resp_discard, flush_buffers, parser_ready;
    logic signed [15:0] read_code;
    logic [7:0] msg_char;
    logic [6:0] msg_len;
    // Verdict counters.
    int mismatches = 0;
    int check_count = 0;
    // Half period of 25 ns gives 20 MHz.
    always #25 clk_sys = ~clk_sys;
    ieq_host_model u_host (.go(go), .sel(sel), .parse(parse), .exec(exec));
    ieq_top #(.MENU_CYCLES(50)) DUT (
        .CLK_SYS(clk_sys), .RST(rst), .PARSE(parse), .EXEC(exec),
        .CLEAR_STATUS(clear_status), .INSTR_RESET(instr_reset), .DEVICE_CLEAR(device_clear),
        .READ_REQ(read_req), .MSG_IDX(msg_idx), .READ_VALID(read_valid), .READ_CODE(read_code),
        .MSG_CHAR(msg_char), .MSG_LEN(msg_len), .MENU_OPEN(menu_open), .MENU_EXIT(menu_exit),
        .MENU_ACTIVITY(menu_activity), .NO_ERRORS_SHOWN(no_errors_shown),
        .ERROR_ANNUNCIATOR(error_annunciator), .BEEP(beep), .CMD_REFUSED(cmd_refused),
        .RESP_DISCARD(resp_discard), .FLUSH_BUFFERS(flush_buffers), .PARSER_READY(parser_ready)
    );
    // Compares one flag.
    task automatic chk_bit(input string what, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", what, e, g);
        end
    endtask : chk_bit
    // Compares one code or character.
    task automatic chk_code(input string what, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk_code
    // One host action; the beep is due at the next falling edge.
    task automatic fire(input logic [4:0] s);
        @(negedge clk_sys);
        sel = s;
        go = 1'b1;
        @(negedge clk_sys);
        go = 1'b0;
    endtask : fire
    // One-cycle pulse on a command input.
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask : pulse
    // Pops one entry and compares its code.
    task automatic rd(input int e);
        pulse(read_req);
        chk_bit("read_valid", 1'b1, read_valid);
        chk_code("read_code", 16'(e), read_code);
    endtask : rd
    // Every action, then one read: code, beep and discard strobe.
    task automatic t_codes();
        for (int i = 0; i < 20; i++) begin
            fire(5'(i));
            chk_bit("beep", EXP[i] != 0, beep);
            chk_bit("discard", EXP[i] == -410 || EXP[i] == -430, resp_discard);
            chk_bit("refused", EXP[i] inside {-168, -170, -223, -211, -213, 514, 550},
                cmd_refused);
            rd(EXP[i]);
        end
    endtask : t_codes
    // Oldest first, annunciator, empty read and its text.
    task automatic t_fifo();
        fire(5'd14);
        fire(5'd17);
        chk_bit("annunciator", 1'b1, error_annunciator);
        rd(511);
        chk_bit("annunciator", 1'b1, error_annunciator);
        rd(514);
        chk_bit("annunciator", 1'b0, error_annunciator);
        rd(0);
        chk_code("no_error_char", 16'h4e, {8'h0, msg_char});
        msg_idx = 7'h64;
        #1;
        chk_code("past_end_char", 16'h20, {8'h0, msg_char});
        msg_idx = 7'h0;
    endtask : t_fifo
    // Twenty-one errors overflow, the next one is dropped but beeps.
    task automatic t_overflow();
        repeat (19) fire(5'd14);
        fire(5'd15);
        fire(5'd16);
        fire(5'd17);
        chk_bit("beep_dropped", 1'b1, beep);
        repeat (19) rd(511);
        rd(-350);
        rd(0);
    endtask : t_overflow
    // Instrument reset keeps entries, clear status empties them.
    task automatic t_clear();
        fire(5'd15);
        fire(5'd16);
        pulse(instr_reset);
        chk_bit("annunciator", 1'b1, error_annunciator);
        rd(512);
        pulse(clear_status);
        chk_bit("annunciator", 1'b0, error_annunciator);
        rd(0);
    endtask : t_clear
    // Activity restarts the idle time; time-out and exit clear.
    task automatic t_menu();
        fire(5'd0);
        menu_open = 1'b1;
        repeat (30) @(negedge clk_sys);
        pulse(menu_activity);
        repeat (30) @(negedge clk_sys);
        chk_bit("annunciator", 1'b1, error_annunciator);
        repeat (30) @(negedge clk_sys);
        chk_bit("annunciator", 1'b0, error_annunciator);
        chk_bit("no_errors_shown", 1'b1, no_errors_shown);
        fire(5'd0);
        pulse(menu_exit);
        chk_bit("annunciator", 1'b0, error_annunciator);
        menu_open = 1'b0;
    endtask : t_menu
    // Device clear flushes the next cycle and keeps the queue.
    task automatic t_devclr();
        fire(5'd16);
        pulse(device_clear);
        chk_bit("flush", 1'b1, flush_buffers);
        chk_bit("parser_ready", 1'b0, parser_ready);
        rd(513);
    endtask : t_devclr
    // Prints the verdict and ends the run.
    task automatic print_verdict();
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    // A hang counts as a mismatch.
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        print_verdict();
    end
    // Main sequence.
    initial begin
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        chk_bit("annunciator", 1'b0, error_annunciator);
        t_fifo();
        t_codes();
        t_overflow();
        t_clear();
        t_menu();
        t_devclr();
        print_verdict();
    end
endmodule : instrument_error_queue_tb_top
